/* File: hw/wk_pkg.sv */
package wk_pkg;
    // register byte offsets
    localparam logic [7:0] WK_OFF_FLAGS   = 8'h00;
    localparam logic [7:0] WK_OFF_LEVEL   = 8'h04;
    localparam logic [7:0] WK_OFF_P2CHG   = 8'h08;
    localparam logic [7:0] WK_OFF_COMBO   = 8'h0C;
    localparam logic [7:0] WK_OFF_P3CHG   = 8'h10;
    localparam logic [7:0] WK_OFF_ROUTE   = 8'h14;
    localparam logic [7:0] WK_OFF_P3DATA  = 8'h18;
    localparam logic [7:0] WK_OFF_P2DATA  = 8'h1C;

    // request flag positions
    localparam int WK_FLAG_PIN_RX = 0;
    localparam int WK_FLAG_WAKE   = 1;
    localparam int WK_FLAG_EXT2   = 2;
    localparam int WK_FLAG_LONG   = 3;
    localparam int WK_FLAG_SHORT  = 4;
    localparam int WK_FLAG_LOWV   = 5;
    localparam int WK_NFLAGS      = 6;

    // level / combo select field layout
    localparam int WK_SEL_LO      = 2;
    localparam int WK_SEL_HI      = 4;
    localparam int WK_OSC_DLY_BIT = 5;
    localparam int WK_POL_BIT     = 6;

    // routing/status field layout
    localparam int WK_ST_P2_LATCHED = 0;
    localparam int WK_ST_P3_LATCHED = 1;
    localparam int WK_ST_BY_WRITE   = 2;
    localparam int WK_RT_ENABLE     = 4;
    localparam int WK_P3_WAKE_PIN   = 3;

    // reset values
    localparam logic [7:0] WK_RST_BYTE  = 8'h00;
    localparam logic [3:0] WK_RST_NIB   = 4'h0;

    // level-select event sources
    typedef enum logic [2:0] {
        WK_LV_NONE  = 3'b000,
        WK_LV_RSVD  = 3'b001,
        WK_LV_P31   = 3'b010,
        WK_LV_P32   = 3'b011,
        WK_LV_P33   = 3'b100,
        WK_LV_P27   = 3'b101,
        WK_LV_NOR4  = 3'b110,
        WK_LV_NOR8  = 3'b111
    } wk_level_e;

    // synchronised pin image
    typedef struct packed {
        logic [7:0] p2;
        logic [3:0] p3;
    } wk_pins_s;
endpackage : wk_pkg

/* File: hw/wk_top.sv */
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - flags read 1 when source requested; bit5 lowvolt
// - bit4 short counter, bit3 long, bit0 pin/rx
// - writing 0 clears flag, writing 1 sets
// - flags frozen until interrupts first enabled
// - routing bit forwards wake to line and pin
// - routed wake reads port3 bit3 as zero
// - port2 selected pins latch, event on difference
// - port3 selected pins latch, event on change
// - combo select picks seven combos, level match
// - status shows latched ports and read/write cause
// - wake is OR of all enabled sources
// - level source: p31-p33, p27 or port2 NOR4/NOR8
// - level field bits4:2, polarity bit6 match
// - codes 000 and 001 give no event
// - level logic ignores outputs and change pins
module wk_top
    import wk_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_N_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output var  logic [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // cpu core
    input  wire logic        EI_EXEC_I,
    input  wire logic [5:0]  REQ_I,
    // port pins and directions
    input  wire logic [7:0]  P2_PIN_I,
    input  wire logic [3:0]  P3_PIN_I,
    input  wire logic [7:0]  P2_OUT_EN_I,
    input  wire logic [3:0]  P3_OUT_EN_I,
    // wake outputs
    output logic             WAKE_O,
    output logic             WAKE_IRQ_LINE_O,
    output logic             P33_WAKE_O,
    output logic             OSC_DELAY_O,
    output logic [5:0]       FLAGS_O
);

    // reset release chain
    // release is synchronous so no flop sees a runt edge
    logic rst_m_r;
    logic rst_n_r;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // pin synchronisers, two stages
    // only the second stage feeds any logic
    wk_pins_s pins_m_r;
    wk_pins_s pins_r;
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pins_m_r <= '0;
            pins_r   <= '0;
        end else begin
            pins_m_r <= '{p2: P2_PIN_I, p3: P3_PIN_I};
            pins_r   <= pins_m_r;
        end
    end

    // register select for one aligned offset
    function automatic logic hit_fn(input logic [7:0] addr,
                                    input logic [7:0] off);
        return addr == off;
    endfunction : hit_fn

    // apb decode
    wire       wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire       rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
    wire       setup = PSEL_I & ~PENABLE_I;
    wire [7:0] wd    = PWDATA_I[7:0];
    wire hit_flags = hit_fn(PADDR_I, WK_OFF_FLAGS);
    wire hit_level = hit_fn(PADDR_I, WK_OFF_LEVEL);
    wire hit_p2chg = hit_fn(PADDR_I, WK_OFF_P2CHG);
    wire hit_combo = hit_fn(PADDR_I, WK_OFF_COMBO);
    wire hit_p3chg = hit_fn(PADDR_I, WK_OFF_P3CHG);
    wire hit_route = hit_fn(PADDR_I, WK_OFF_ROUTE);
    wire hit_p3dat = hit_fn(PADDR_I, WK_OFF_P3DATA);
    wire hit_p2dat = hit_fn(PADDR_I, WK_OFF_P2DATA);
    wire hit_any   = hit_flags | hit_level | hit_p2chg | hit_combo
                   | hit_p3chg | hit_route | hit_p3dat | hit_p2dat;

    // zero-wait slave, error on unmapped address
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit_any;

    // per-register write strobes
    wire wr_flags = wr_en & hit_flags;
    wire wr_level = wr_en & hit_level;
    wire wr_p2chg = wr_en & hit_p2chg;
    wire wr_combo = wr_en & hit_combo;
    wire wr_p3chg = wr_en & hit_p3chg;
    wire wr_route = wr_en & hit_route;

    // configuration registers
    logic [7:0] level_r;
    logic [7:0] p2sel_r;
    logic [7:0] combo_r;
    logic [3:0] p3sel_r;
    logic       route_en_r;
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            level_r    <= WK_RST_BYTE;
            p2sel_r    <= WK_RST_BYTE;
            combo_r    <= WK_RST_BYTE;
            p3sel_r    <= WK_RST_NIB;
            route_en_r <= 1'b0;
        end else begin
            if (wr_level) level_r    <= wd;
            if (wr_p2chg) p2sel_r    <= wd;
            if (wr_combo) combo_r    <= wd;
            if (wr_p3chg) p3sel_r    <= wd[3:0];
            if (wr_route) route_en_r <= wd[WK_RT_ENABLE];
        end
    end
    assign OSC_DELAY_O = level_r[WK_OSC_DLY_BIT];

    // change-detect latches, loaded by port reads and writes
    wire p2_rd = rd_en & hit_p2dat;
    wire p2_wr = wr_en & hit_p2dat;
    wire p3_rd = rd_en & hit_p3dat;
    wire p3_wr = wr_en & hit_p3dat;
    logic [7:0] p2_latch_r;
    logic [3:0] p3_latch_r;
    logic       p2_latched_r;
    logic       p3_latched_r;
    logic       by_write_r;
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            p2_latch_r   <= WK_RST_BYTE;
            p3_latch_r   <= WK_RST_NIB;
            p2_latched_r <= 1'b0;
            p3_latched_r <= 1'b0;
            by_write_r   <= 1'b0;
        end else begin
            if (p2_rd | p2_wr) begin
                p2_latch_r   <= p2_wr ? wd : pins_r.p2;
                p2_latched_r <= 1'b1;
                by_write_r   <= p2_wr;
            end
            if (p3_rd | p3_wr) begin
                p3_latch_r   <= p3_wr ? wd[3:0] : pins_r.p3;
                p3_latched_r <= 1'b1;
                by_write_r   <= p3_wr;
            end
        end
    end

    // change events per selected pin
    logic [7:0] p2_chg_bit;
    logic [3:0] p3_chg_bit;
    for (genvar i = 0; i < 8; i++) begin : g_p2_chg
        assign p2_chg_bit[i] = p2sel_r[i]
                             & (pins_r.p2[i] ^ p2_latch_r[i]);
    end
    for (genvar i = 0; i < 4; i++) begin : g_p3_chg
        assign p3_chg_bit[i] = p3sel_r[i]
                             & (pins_r.p3[i] ^ p3_latch_r[i]);
    end
    wire p2_chg_ev = |p2_chg_bit;
    wire p3_chg_ev = |p3_chg_bit;

    // an output pin only echoes our own drive, so it is left out
    // pins usable by level logic: inputs not watched for change
    wire [7:0] p2_use = ~P2_OUT_EN_I & ~p2sel_r;
    wire [3:0] p3_use = ~P3_OUT_EN_I & ~p3sel_r;
    wire [7:0] p2_lv  = pins_r.p2 & p2_use;
    wire [3:0] p3_lv  = pins_r.p3 & p3_use;

    // level-select logic output and validity
    wk_level_e lv_sel;
    logic      lv_out;
    logic      lv_ok;
    assign lv_sel = wk_level_e'(level_r[WK_SEL_HI:WK_SEL_LO]);
    always_comb begin
        lv_out = 1'b0;
        lv_ok  = 1'b1;
        unique case (lv_sel)
            WK_LV_NONE: lv_ok = 1'b0;
            WK_LV_RSVD: lv_ok = 1'b0;
            WK_LV_P31: begin
                lv_out = p3_lv[1];
                lv_ok  = p3_use[1];
            end
            WK_LV_P32: begin
                lv_out = p3_lv[2];
                lv_ok  = p3_use[2];
            end
            WK_LV_P33: begin
                lv_out = p3_lv[3];
                lv_ok  = p3_use[3];
            end
            WK_LV_P27: begin
                lv_out = p2_lv[7];
                lv_ok  = p2_use[7];
            end
            WK_LV_NOR4: begin
                lv_out = ~|p2_lv[3:0];
                lv_ok  = |p2_use[3:0];
            end
            WK_LV_NOR8: begin
                lv_out = ~|p2_lv;
                lv_ok  = |p2_use;
            end
        endcase
    end
    // no event without a usable source pin
    wire lv_ev = lv_ok & (lv_out == level_r[WK_POL_BIT]);

    // seven port2/port3 combinations for the combo register
    function automatic logic combo_fn(input logic [2:0] sel,
                                      input logic [7:0] p2,
                                      input logic [3:0] p3);
        logic r;
        r = 1'b0;
        unique case (sel)
            3'b000: r = 1'b0;
            3'b001: r = ~|(p2[3:0] | p3[3:0]);
            3'b010: r = &p2[3:0] & &p3[3:0];
            3'b011: r = ~|(p2[7:4] | p3[3:0]);
            3'b100: r = &p2[7:4] & &p3[3:0];
            3'b101: r = ~|p2 & ~|p3;
            3'b110: r = &p2 & &p3;
            3'b111: r = ^{p2, p3};
        endcase
        return r;
    endfunction
    // code 000 switches the combo source off
    wire [2:0] cb_sel = combo_r[WK_SEL_HI:WK_SEL_LO];
    wire cb_out = combo_fn(cb_sel, pins_r.p2, pins_r.p3);
    wire cb_ev  = (cb_sel != 3'h0)
                & (cb_out == combo_r[WK_POL_BIT]);

    // overall wake event
    assign WAKE_O = lv_ev | p2_chg_ev | p3_chg_ev | cb_ev;
    wire   routed = route_en_r & WAKE_O;
    assign WAKE_IRQ_LINE_O = routed;
    assign P33_WAKE_O      = routed;

    // routed wake rising edge sets the wake flag once per event
    // an edge, so a clear while the wake still stands sticks
    logic routed_d_r;
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            routed_d_r <= 1'b0;
        end else begin
            routed_d_r <= routed;
        end
    end
    wire routed_rise = routed & ~routed_d_r;

    // interrupts-enabled-once latch
    logic ei_seen_r;
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ei_seen_r <= 1'b0;
        end else if (EI_EXEC_I) begin
            ei_seen_r <= 1'b1;
        end
    end

    // request flags: hardware set wins over a software clear
    logic [5:0] flags_r;
    logic [5:0] flags_nxt;
    logic [5:0] hw_set;
    always_comb begin
        hw_set = REQ_I;
        hw_set[WK_FLAG_WAKE] = REQ_I[WK_FLAG_WAKE] | routed_rise;
        flags_nxt = flags_r;
        if (wr_flags)
            flags_nxt = wd[WK_NFLAGS-1:0];
        flags_nxt = flags_nxt | hw_set;
    end
    // whole register frozen until interrupts enabled once
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flags_r <= '0;
        end else if (ei_seen_r) begin
            flags_r <= flags_nxt;
        end
    end
    assign FLAGS_O = flags_r;

    // port3 data view: bit3 low while a routed wake is active
    logic [3:0] p3_view;
    always_comb begin
        p3_view = pins_r.p3;
        if (routed) p3_view[WK_P3_WAKE_PIN] = 1'b0;
    end

    // routing/status view: enable plus read-only latch state
    logic [7:0] route_view;
    always_comb begin
        route_view                   = WK_RST_BYTE;
        route_view[WK_ST_P2_LATCHED] = p2_latched_r;
        route_view[WK_ST_P3_LATCHED] = p3_latched_r;
        route_view[WK_ST_BY_WRITE]   = by_write_r;
        route_view[WK_RT_ENABLE]     = route_en_r;
    end

    // read mux and registered read data
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_flags) rd_mux = {2'h0, flags_r};
        if (hit_level) rd_mux = level_r;
        if (hit_p2chg) rd_mux = p2sel_r;
        if (hit_combo) rd_mux = combo_r;
        if (hit_p3chg) rd_mux = {4'h0, p3sel_r};
        if (hit_route) rd_mux = route_view;
        if (hit_p3dat) rd_mux = {4'h0, p3_view};
        if (hit_p2dat) rd_mux = pins_r.p2;
    end
    // captured at setup so it stands through the access edge
    always_ff @(posedge SYS_CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (setup) begin
            PRDATA_O <= {24'h00_0000, rd_mux};
        end
    end

endmodule : wk_top
`default_nettype wire

/* File: testbench/wake_event_and_irq_flags_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module wake_event_and_irq_flags_tb
    import wk_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ei = 0;
    logic [7:0] paddr = '0, p2c = '0, p2oe = '0, p2;
    logic [3:0] p3c = '0, p3oe = '0, p3;
    logic [31:0] pwd = '0, prd, q;
    logic [5:0] req = '0, flags;
    logic rdy, err, e, wake, line, p33, osc;
    int err_count = 0, num_checks = 0, cyc = 0;
    // clock
    always #10 clk = ~clk;
    wk_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
        .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .EI_EXEC_I(ei),
        .REQ_I(req), .P2_PIN_I(p2), .P3_PIN_I(p3), .P2_OUT_EN_I(p2oe),
        .P3_OUT_EN_I(p3oe), .WAKE_O(wake), .WAKE_IRQ_LINE_O(line),
        .P33_WAKE_O(p33), .OSC_DELAY_O(osc), .FLAGS_O(flags));
    wk_pin_model pins (.p2_cmd_i(p2c), .p3_cmd_i(p3c), .p2_o(p2), .p3_o(p3));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    // one bus transfer, result in q and e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        e = err;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task pin(input logic [7:0] a, input logic [3:0] b);
        @(posedge clk);
        p2c <= a;
        p3c <= b;
        wt(4);
    endtask : pin
    task t_frozen;
        apb(1, WK_OFF_FLAGS, 32'h0000_003F);
        @(posedge clk);
        req <= 6'h3F;
        @(posedge clk);
        req <= 6'h00;
        apb(0, WK_OFF_FLAGS, 32'h0);
        chk(q, 32'h0, "frozen");
        @(posedge clk);
        ei <= 1;
        @(posedge clk);
        ei <= 0;
        $display("t_frozen done");
    endtask : t_frozen
    task t_flags;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            req <= 6'h01 << i;
            @(posedge clk);
            req <= 6'h00;
            apb(0, WK_OFF_FLAGS, 32'h0);
            chk(q, 32'h1 << i, "hw flag");
            apb(1, WK_OFF_FLAGS, 32'h0);
        end
        apb(1, WK_OFF_FLAGS, 32'h0000_002A);
        apb(0, WK_OFF_FLAGS, 32'h0);
        chk(q, 32'h0000_002A, "sw set");
        apb(1, WK_OFF_FLAGS, 32'h0000_0015);
        apb(0, WK_OFF_FLAGS, 32'h0);
        chk(q, 32'h0000_0015, "sw clear");
        apb(1, WK_OFF_FLAGS, 32'h0);
        $display("t_flags done");
    endtask : t_flags
    task t_p2chg;
        apb(1, WK_OFF_ROUTE, 32'h0000_0010);
        apb(1, WK_OFF_P2DATA, 32'h0);
        apb(1, WK_OFF_P2CHG, 32'h0000_0001);
        wt(2);
        chk(wake, 0, "p2 quiet");
        pin(8'h01, 4'h0);
        chk(line, 1, "p2 line");
        chk(p33, 1, "p33 pin");
        apb(0, WK_OFF_ROUTE, 32'h0);
        chk(q[4:0], 5'h15, "p2 status");
        pin(8'h01, 4'h8);
        apb(0, WK_OFF_P3DATA, 32'h0);
        chk(q[3:0], 4'h0, "p33 cause");
        apb(1, WK_OFF_P2CHG, 32'h0);
        apb(0, WK_OFF_P3DATA, 32'h0);
        chk(q[3:0], 4'h8, "p33 released");
        pin(8'h00, 4'h0);
        apb(0, WK_OFF_FLAGS, 32'h0);
        chk(q, 32'h0000_0002, "wake flag");
        apb(1, WK_OFF_FLAGS, 32'h0);
        apb(0, WK_OFF_FLAGS, 32'h0);
        chk(q, 32'h0, "wake clear");
        $display("t_p2chg done");
    endtask : t_p2chg
    task t_p3chg;
        apb(0, WK_OFF_P3DATA, 32'h0);
        apb(1, WK_OFF_P3CHG, 32'h0000_0004);
        pin(8'h00, 4'h4);
        chk(wake, 1, "p3 change");
        apb(0, WK_OFF_ROUTE, 32'h0);
        chk({q[2], q[1]}, 2'b01, "p3 status");
        apb(1, WK_OFF_P3CHG, 32'h0);
        pin(8'h00, 4'h0);
        $display("t_p3chg done");
    endtask : t_p3chg
    task t_level;
        apb(1, WK_OFF_LEVEL, 32'h0000_0048);
        pin(8'h00, 4'h2);
        chk(wake, 1, "level hit");
        @(posedge clk);
        p3oe <= 4'h2;
        wt(2);
        chk(wake, 0, "output pin");
        @(posedge clk);
        p3oe <= 4'h0;
        apb(0, WK_OFF_P3DATA, 32'h0);
        apb(1, WK_OFF_P3CHG, 32'h0000_0002);
        wt(2);
        chk(wake, 0, "change pin");
        apb(1, WK_OFF_P3CHG, 32'h0);
        apb(1, WK_OFF_LEVEL, 32'h0000_0008);
        wt(2);
        chk(wake, 0, "polarity");
        for (int c = 0; c < 2; c++) begin
            apb(1, WK_OFF_LEVEL, 32'h0000_0020 | (c << 2));
            pin(8'h00, 4'h0);
            chk(wake, 0, "no source");
            chk(osc, 1, "osc bit");
        end
        apb(1, WK_OFF_LEVEL, 32'h0);
        $display("t_level done");
    endtask : t_level
    task t_combo;
        apb(1, WK_OFF_COMBO, 32'h0000_0058);
        pin(8'hFF, 4'hF);
        chk(wake, 1, "combo hit");
        pin(8'hFE, 4'hF);
        chk(wake, 0, "combo miss");
        apb(1, WK_OFF_COMBO, 32'h0);
        pin(8'h00, 4'h0);
        apb(0, 8'h20, 32'h0);
        chk(e, 1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        $display("t_combo done");
    endtask : t_combo
    // every combo code 1-7, then level codes 2-7, polarity 1
    task t_modes;
        logic [11:0] hit [13];
        logic [11:0] miss [13];
        hit  = '{12'hF00, 12'h0FF, 12'h0F0, 12'hF0F, 12'h000, 12'hFFF,
                 12'h010, 12'h002, 12'h004, 12'h008, 12'h800, 12'hF00,
                 12'h000};
        miss = '{12'hF10, 12'h0EF, 12'h1F0, 12'hF0E, 12'h001, 12'hFEF,
                 12'h030, 12'h000, 12'h000, 12'h000, 12'h000, 12'hF10,
                 12'h010};
        for (int k = 0; k < 13; k++) begin
            if (k < 7)
                apb(1, WK_OFF_COMBO, 32'h0000_0040 | ((k + 1) << 2));
            else
                apb(1, WK_OFF_LEVEL, 32'h0000_0040 | ((k - 5) << 2));
            pin(hit[k][11:4], hit[k][3:0]);
            chk(wake, 1, "code hit");
            pin(miss[k][11:4], miss[k][3:0]);
            chk(wake, 0, "code miss");
            if (k == 6)
                apb(1, WK_OFF_COMBO, 32'h0);
        end
        apb(1, WK_OFF_LEVEL, 32'h0);
        pin(8'h00, 4'h0);
        $display("t_modes done");
    endtask : t_modes
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        wt(4);
        t_frozen();
        t_flags();
        t_p2chg();
        t_p3chg();
        t_level();
        t_combo();
        t_modes();
        end_sim();
    end
endmodule : wake_event_and_irq_flags_tb
bind wk_top wk_assertions u_chk (.SYS_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .EI_EXEC_I, .REQ_I, .WAKE_O,
    .WAKE_IRQ_LINE_O, .P33_WAKE_O, .FLAGS_O);
`default_nettype wire

/* File: testbench/wk_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module wk_assertions
    import wk_pkg::*;
(
    // clock, reset, bus
    input wire logic        SYS_CLK_I,
    input wire logic        RST_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PREADY_O,
    // requests and wake
    input wire logic        EI_EXEC_I,
    input wire logic [5:0]  REQ_I,
    input wire logic        WAKE_O,
    input wire logic        WAKE_IRQ_LINE_O,
    input wire logic        P33_WAKE_O,
    input wire logic [5:0]  FLAGS_O
);
    logic       ei_seen_r;
    logic       fwr;
    logic [5:0] wd6;
    // remembers that interrupts were enabled once
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            ei_seen_r <= 1'b0;
        else if (EI_EXEC_I)
            ei_seen_r <= 1'b1;
    end
    // flag register write in access phase
    assign fwr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == WK_OFF_FLAGS;
    assign wd6 = PWDATA_I[5:0];
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_line_needs_wake: assert property (WAKE_IRQ_LINE_O |-> WAKE_O)
        else $error("wake line without wake");
    a_pin_follows_line: assert property (P33_WAKE_O == WAKE_IRQ_LINE_O)
        else $error("pin differs from wake line");
    a_frozen_pre_ei: assert property (!ei_seen_r && !EI_EXEC_I |=>
        $stable(FLAGS_O)) else $error("flags moved before enable");
    a_hw_req_sets: assert property (ei_seen_r && |REQ_I |=>
        (FLAGS_O & $past(REQ_I)) == $past(REQ_I))
        else $error("request not flagged");
    a_write_loads: assert property (ei_seen_r && fwr && REQ_I == 6'h00
        && !WAKE_IRQ_LINE_O |=> FLAGS_O == $past(wd6))
        else $error("flag write lost");
    a_wake_sets_flag: assert property (ei_seen_r && $rose(WAKE_IRQ_LINE_O) |=>
        FLAGS_O[WK_FLAG_WAKE]) else $error("wake flag not set");
    a_flags_hold: assert property (ei_seen_r && !fwr && REQ_I == 6'h00
        && !WAKE_IRQ_LINE_O |=> $stable(FLAGS_O))
        else $error("flags changed unasked");
    a_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("access not ready");
    c_flag_write: cover property (ei_seen_r && fwr);
    c_wake_line: cover property (WAKE_IRQ_LINE_O);
    c_ei: cover property (EI_EXEC_I);
endmodule : wk_assertions
`default_nettype wire

/* File: testbench/wk_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module wk_pin_model (
    // commanded levels
    input  wire logic [7:0] p2_cmd_i,
    input  wire logic [3:0] p3_cmd_i,
    // pins, moving off the clock grid
    output logic      [7:0] p2_o,
    output logic      [3:0] p3_o
);
    assign #3 p2_o = p2_cmd_i;
    assign #3 p3_o = p3_cmd_i;
endmodule : wk_pin_model
`default_nettype wire
